//--- logic/scm_mixer_clipper.sv
// stereo gain coupling, band mixer and three-way multi-band clipper
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps

module scm_mixer_clipper #(
  parameter int LP_SHIFT    = scm_pkg::LP_SHIFT_RST,
  parameter int BP_LO_SHIFT = scm_pkg::BP_LO_SHIFT_RST,
  parameter int BP_HI_SHIFT = scm_pkg::BP_HI_SHIFT_RST,
  parameter int HP_SHIFT    = scm_pkg::HP_SHIFT_RST
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [3:0]         addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [15:0]             rdata,
  input  wire logic               in_valid,
  input  wire scm_pkg::scm_bands_t bands_in,
  input  wire scm_pkg::scm_gr_t   gr_in,
  output logic                    out_valid,
  output scm_pkg::scm_paths_t     paths_out,
  output scm_pkg::scm_gr_t        gr_out,
  output logic [15:0]             gr_report
);

  // ***********************************************************************
  // arithmetic helpers
  // ***********************************************************************
  function automatic scm_pkg::scm_sample_t sat16(input logic signed [33:0] v);
    if (v > $signed({18'h00000, scm_pkg::SAMPLE_MAX}))
      return scm_pkg::SAMPLE_MAX;
    else if (v < $signed({18'h3FFFF, scm_pkg::SAMPLE_MIN}))
      return scm_pkg::SAMPLE_MIN;
    else
      return v[15:0];
  endfunction

  // gain is unsigned q2.14; a wrap here would hit the clippers as a full-scale flip
  function automatic scm_pkg::scm_sample_t mul_q14(input scm_pkg::scm_sample_t x,
                                                   input logic [15:0] g);
    logic signed [32:0] p;
    p = x * $signed({1'b0, g});
    // signed shift keeps negative products negative instead of saturating high
    return sat16($signed({p[32], p}) >>> scm_pkg::Q14_SHIFT);
  endfunction

  function automatic scm_pkg::scm_sample_t add_sat(input scm_pkg::scm_sample_t a,
                                                   input scm_pkg::scm_sample_t b);
    return sat16({{18{a[15]}}, a} + {{18{b[15]}}, b});
  endfunction

  function automatic scm_pkg::scm_sample_t sub_sat(input scm_pkg::scm_sample_t a,
                                                   input scm_pkg::scm_sample_t b);
    return sat16({{18{a[15]}}, a} - {{18{b[15]}}, b});
  endfunction

  // threshold is a magnitude against the final clip level at full scale
  function automatic scm_pkg::scm_sample_t clip(input scm_pkg::scm_sample_t x,
                                                input logic [15:0] thr);
    logic signed [16:0] t;
    t = {2'b00, thr[14:0]};
    if ($signed({x[15], x}) > t)
      return t[15:0];
    else if ($signed({x[15], x}) < -t)
      return 16'(-t);
    else
      return x;
  endfunction

  // one-pole low-pass, coefficient is a power of two to avoid a multiplier
  function automatic scm_pkg::scm_sample_t lp_step(input scm_pkg::scm_sample_t y,
                                                   input scm_pkg::scm_sample_t x,
                                                   input int sh);
    logic signed [16:0] d;
    d = {x[15], x} - {y[15], y};
    d = d >>> sh;
    return sat16({{18{y[15]}}, y} + {{17{d[16]}}, d});
  endfunction

  // moves own reduction toward the larger one by pct percent
  function automatic logic [15:0] couple(input logic [15:0] own,
                                         input logic [15:0] big,
                                         input logic [15:0] pct);
    logic [39:0] p;
    p = 40'(big - own) * 40'(pct) * 40'(scm_pkg::COUPLE_RECIP);
    if (pct >= scm_pkg::COUPLING_FULL)
      return big;
    else if (pct == 16'h0000)
      return own;
    else
      return own + 16'(p >> scm_pkg::RECIP_SHIFT);
  endfunction

  function automatic logic [15:0] clamp_trim(input logic [15:0] g);
    if (g < scm_pkg::TRIM_MIN)
      return scm_pkg::TRIM_MIN;
    else if (g > scm_pkg::TRIM_MAX)
      return scm_pkg::TRIM_MAX;
    else
      return g;
  endfunction

  // ***********************************************************************
  // state
  // ***********************************************************************
  scm_pkg::scm_state_t state;
  scm_pkg::scm_state_t next_state;

  always_comb
  begin
    logic [15:0]             big;
    scm_pkg::scm_sample_t [3:0] trimmed;
    scm_pkg::scm_sample_t    sum12;
    scm_pkg::scm_sample_t    c_bass;
    scm_pkg::scm_sample_t    c_mid;
    scm_pkg::scm_sample_t    c_tre;
    scm_pkg::scm_sample_t    hp_mid;
    big     = 16'h0000;
    trimmed = '0;
    sum12   = 16'h0000;
    c_bass  = 16'h0000;
    c_mid   = 16'h0000;
    c_tre   = 16'h0000;
    hp_mid  = 16'h0000;
    next_state = state;
    next_state.out_valid = 1'b0;
    next_state.rdata     = 16'h0000;

    // register writes
    if (wr)
    begin
      unique case (addr)
        scm_pkg::REG_COUPLING: next_state.couple_pct = wdata;
        scm_pkg::REG_SOLO:
        begin
          next_state.solo_en  = wdata[scm_pkg::SOLO_EN_BIT];
          next_state.solo_sel = wdata[scm_pkg::SOLO_SEL_LSB +: 2];
        end
        scm_pkg::REG_DRIVE: next_state.drive = wdata;
        default:
        begin
          if (addr >= scm_pkg::REG_TRIM_BASE && addr < scm_pkg::REG_SOLO)
            next_state.trim[2'(addr - scm_pkg::REG_TRIM_BASE)] = clamp_trim(wdata);
          else if (addr >= scm_pkg::REG_THR_BASE && addr < scm_pkg::REG_GR_REPORT)
            next_state.thr[2'(addr - scm_pkg::REG_THR_BASE)] = {1'b0, wdata[14:0]};
        end
      endcase
    end

    // register reads, answer stands for one cycle; unmapped reads zero
    if (rd)
    begin
      unique case (addr)
        scm_pkg::REG_COUPLING:  next_state.rdata = state.couple_pct;
        scm_pkg::REG_SOLO:      next_state.rdata = {13'h0000, state.solo_sel, state.solo_en};
        scm_pkg::REG_DRIVE:     next_state.rdata = state.drive;
        scm_pkg::REG_GR_REPORT: next_state.rdata = state.gr_report;
        scm_pkg::REG_GR_LEFT:   next_state.rdata = state.gr.left;
        scm_pkg::REG_GR_RIGHT:  next_state.rdata = state.gr.right;
        default:
        begin
          if (addr >= scm_pkg::REG_TRIM_BASE && addr < scm_pkg::REG_SOLO)
            next_state.rdata = state.trim[2'(addr - scm_pkg::REG_TRIM_BASE)];
          else if (addr >= scm_pkg::REG_THR_BASE && addr < scm_pkg::REG_GR_REPORT)
            next_state.rdata = state.thr[2'(addr - scm_pkg::REG_THR_BASE)];
        end
      endcase
    end

    // sample processing, one sample per in_valid
    if (in_valid)
    begin
      big = (gr_in.left > gr_in.right) ? gr_in.left : gr_in.right;
      next_state.gr.left   = couple(gr_in.left, big, state.couple_pct);
      next_state.gr.right  = couple(gr_in.right, big, state.couple_pct);
      next_state.gr_report = big;

      for (int i = 0; i < 4; i++)
      begin
        if (state.solo_en && state.solo_sel != 2'(i))
          trimmed[i] = 16'h0000;
        else
          trimmed[i] = mul_q14(bands_in.band[i], state.trim[i]);
      end
      sum12 = add_sat(trimmed[0], trimmed[1]);

      // drive sits on top of the trims; all three clippers share it
      c_bass = clip(mul_q14(sum12, state.drive), state.thr[0]);
      c_mid  = clip(mul_q14(trimmed[2], state.drive), state.thr[1]);
      c_tre  = clip(mul_q14(trimmed[3], state.drive), state.thr[2]);

      // each clipper owns its filter state so the paths never interact
      next_state.lp_bass = lp_step(state.lp_bass, c_bass, LP_SHIFT);
      next_state.bp_lo   = lp_step(state.bp_lo, c_mid, BP_LO_SHIFT);
      hp_mid             = sub_sat(c_mid, next_state.bp_lo);
      next_state.bp_hi   = lp_step(state.bp_hi, hp_mid, BP_HI_SHIFT);
      next_state.hp_lp   = lp_step(state.hp_lp, c_tre, HP_SHIFT);

      next_state.paths.bass   = next_state.lp_bass;
      next_state.paths.mid    = next_state.bp_hi;
      next_state.paths.treble = sub_sat(c_tre, next_state.hp_lp);
      next_state.out_valid    = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state            <= '0;
      state.couple_pct <= scm_pkg::COUPLING_RST;
      state.trim       <= {4{scm_pkg::UNITY_Q14}};
      state.drive      <= scm_pkg::DRIVE_RST;
      state.thr        <= {3{scm_pkg::THR_RST}};
    end
    else
      state <= next_state;
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign rdata     = state.rdata;
  assign out_valid = state.out_valid;
  assign paths_out = state.paths;
  assign gr_out    = state.gr;
  assign gr_report = state.gr_report;

endmodule // scm_mixer_clipper

//--- logic/scm_pkg.sv
// constants and types shared by the stereo coupling, band mixer and clipper stage
package scm_pkg;

  // ***********************************************************************
  // register map, word addresses on the plain register port
  // ***********************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] REG_COUPLING   = 4'h0;
  localparam logic [3:0] REG_TRIM_BASE  = 4'h1;
  localparam logic [3:0] REG_SOLO       = 4'h5;
  localparam logic [3:0] REG_DRIVE      = 4'h6;
  localparam logic [3:0] REG_THR_BASE   = 4'h7;
  localparam logic [3:0] REG_GR_REPORT  = 4'hA;
  localparam logic [3:0] REG_GR_LEFT    = 4'hB;
  localparam logic [3:0] REG_GR_RIGHT   = 4'hC;

  localparam int SOLO_EN_BIT  = 0;
  localparam int SOLO_SEL_LSB = 1;

  // ***********************************************************************
  // values after reset and fixed-point figures
  // ***********************************************************************
  localparam logic [15:0] COUPLING_RST  = 16'h0000;
  localparam logic [15:0] COUPLING_FULL = 16'h0064;
  localparam logic [15:0] COUPLE_RECIP  = 16'h028F;
  localparam logic [15:0] UNITY_Q14     = 16'h4000;
  localparam logic [15:0] TRIM_MIN      = 16'h2D4E;
  localparam logic [15:0] TRIM_MAX      = 16'h5A67;
  localparam logic [15:0] DRIVE_RST     = 16'h4000;
  localparam logic [15:0] THR_RST       = 16'h7FFF;
  localparam logic [15:0] SAMPLE_MAX    = 16'h7FFF;
  localparam logic [15:0] SAMPLE_MIN    = 16'h8000;
  localparam int          Q14_SHIFT     = 14;
  localparam int          RECIP_SHIFT   = 16;

  localparam int LP_SHIFT_RST    = 3;
  localparam int BP_LO_SHIFT_RST = 6;
  localparam int BP_HI_SHIFT_RST = 2;
  localparam int HP_SHIFT_RST    = 5;

  // ***********************************************************************
  // carriers
  // ***********************************************************************
  typedef logic signed [15:0] scm_sample_t;

  typedef struct packed {
    scm_sample_t [3:0] band;
  } scm_bands_t;

  typedef struct packed {
    scm_sample_t bass;
    scm_sample_t mid;
    scm_sample_t treble;
  } scm_paths_t;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } scm_gr_t;

  typedef struct packed {
    logic [15:0]       couple_pct;
    logic [3:0][15:0]  trim;
    logic              solo_en;
    logic [1:0]        solo_sel;
    logic [15:0]       drive;
    logic [2:0][15:0]  thr;
    logic [15:0]       rdata;
    logic              out_valid;
    scm_paths_t        paths;
    scm_gr_t           gr;
    logic [15:0]       gr_report;
    scm_sample_t       lp_bass;
    scm_sample_t       bp_lo;
    scm_sample_t       bp_hi;
    scm_sample_t       hp_lp;
  } scm_state_t;

endpackage

//--- tb/scm_chk_sva.sv
// port assertions for the mixer clipper stage
`timescale 1ns/1ps
module scm_chk (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                in_valid,
  input wire scm_pkg::scm_gr_t    gr_in,
  input wire logic                out_valid,
  input wire scm_pkg::scm_paths_t paths_out,
  input wire scm_pkg::scm_gr_t    gr_out,
  input wire logic [15:0]         gr_report
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [15:0] big;
  assign big = (gr_in.left > gr_in.right) ? gr_in.left : gr_in.right;
  a_out_follow: assert property (in_valid |=> out_valid)
    else $error("no output strobe after sample");
  a_out_pulse: assert property (!in_valid |=> !out_valid)
    else $error("output strobe without sample");
  a_report_max: assert property (in_valid |=> gr_report == $past(big))
    else $error("reported reduction not the larger one");
  a_couple_low: assert property (in_valid |=>
    gr_out.left >= $past(gr_in.left) && gr_out.right >= $past(gr_in.right))
    else $error("coupled reduction below own");
  a_couple_high: assert property (in_valid |=>
    gr_out.left <= $past(big) && gr_out.right <= $past(big))
    else $error("coupled reduction above larger");
  a_gr_hold: assert property (!in_valid |=> $stable(gr_out) && $stable(gr_report))
    else $error("reduction moved between samples");
  a_paths_hold: assert property (!in_valid |=> $stable(paths_out))
    else $error("paths moved between samples");
  a_report_top: assert property (gr_report >= gr_out.left && gr_report >= gr_out.right)
    else $error("coupled reduction above report");
  cover property (in_valid ##1 out_valid);
  cover property (in_valid && gr_in.left != gr_in.right);
  cover property (out_valid && paths_out.bass != 16'h0000);
endmodule // scm_chk

bind scm_mixer_clipper scm_chk u_chk (.clock(clock), .rst(rst), .in_valid(in_valid),
  .gr_in(gr_in), .out_valid(out_valid), .paths_out(paths_out), .gr_out(gr_out),
  .gr_report(gr_report));

//--- tb/scm_limiter_model.sv
// upstream limiter model feeding band samples and gain reduction
`timescale 1ns/1ps
module scm_limiter_model (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                send,
  input wire scm_pkg::scm_bands_t bands,
  input wire scm_pkg::scm_gr_t    gr,
  output scm_pkg::scm_bands_t     bands_in,
  output scm_pkg::scm_gr_t        gr_in,
  output logic                    in_valid
);
  // between strobes the lines toggle so stale data never passes for fresh
  always_ff @(posedge clock)
  begin
    in_valid <= send && !rst;
    bands_in <= send ? bands : (rst ? '0 : ~bands_in);
    gr_in    <= send ? gr : (rst ? '0 : ~gr_in);
  end
endmodule // scm_limiter_model

//--- tb/scm_mixer_clipper_tb.sv
// self-checking bench for the mixer clipper stage
`timescale 1ns/1ps
module scm_mixer_clipper_tb;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic [3:0]          addr = 4'h0;
  logic [15:0]         wdata = 16'h0000;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic                send = 1'b0;
  scm_pkg::scm_bands_t bands = '0;
  scm_pkg::scm_gr_t    gr = '0;
  logic [15:0]         rdata;
  logic                in_valid;
  logic                out_valid;
  logic [15:0]         gr_report;
  scm_pkg::scm_bands_t bands_in;
  scm_pkg::scm_gr_t    gr_in;
  scm_pkg::scm_gr_t    gr_out;
  scm_pkg::scm_paths_t paths_out;
  int                  fail_count = 0;
  int                  checks = 0;
  logic [15:0]         rst_tab [10] = '{16'h0000, 16'h4000, 16'h4000, 16'h4000,
    16'h4000, 16'h0000, 16'h4000, 16'h7FFF, 16'h7FFF, 16'h7FFF};
  logic [15:0]         cp_tab [4] = '{16'h0000, 16'h0032, 16'h0064, 16'h00C8};
  logic [15:0]         gl_tab [4] = '{16'h0064, 16'h00C7, 16'h012C, 16'h012C};

  always #20 clock = ~clock;

  scm_limiter_model u_lim (.clock(clock), .rst(rst), .send(send), .bands(bands),
    .gr(gr), .bands_in(bands_in), .gr_in(gr_in), .in_valid(in_valid));
  scm_mixer_clipper dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .bands_in(bands_in),
    .gr_in(gr_in), .out_valid(out_valid), .paths_out(paths_out), .gr_out(gr_out),
    .gr_report(gr_report));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // the model registers the request, so the answer lands two edges later
  task automatic smp(input logic [63:0] b, input logic [31:0] g);
    @(posedge clock);
    send <= 1'b1;
    bands <= b;
    gr <= g;
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic paths(input logic [15:0] b, input logic [15:0] m, input logic [15:0] t);
    chk(paths_out.bass, b);
    chk(paths_out.mid, m);
    chk(paths_out.treble, t);
  endtask
  task automatic final_report;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    do_reset;
    for (int i = 0; i < 10; i++)
      rd_reg(i[3:0], rst_tab[i]);
    rd_reg(4'hD, 16'h0000);
    wr_reg(4'h1, 16'h7000);
    rd_reg(4'h1, 16'h5A67);
    wr_reg(4'h4, 16'h1000);
    rd_reg(4'h4, 16'h2D4E);
    wr_reg(4'h7, 16'hFFFF);
    rd_reg(4'h7, 16'h7FFF);
    wr_reg(4'hA, 16'h1234);
    rd_reg(4'hA, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(4'h0, cp_tab[i]);
      smp(64'h0, 32'h0064_012C);
      chk(gr_out.left, gl_tab[i]);
      chk(gr_out.right, 16'h012C);
      chk(gr_report, 16'h012C);
      rd_reg(4'hB, gl_tab[i]);
    end
    do_reset;
    smp(64'h4000_2000_0800_1000, 32'h0);
    paths(16'h0300, 16'h07E0, 16'h3E00);
    smp(64'h4000_2000_0800_1000, 32'h0);
    paths(16'h05A0, 16'h0DA8, 16'h3C10);
    do_reset;
    smp(64'hC000_E000_F800_F000, 32'h0);
    paths(16'hFD00, 16'hF820, 16'hC200);
    do_reset;
    wr_reg(4'h1, 16'h5A67);
    wr_reg(4'h6, 16'h8000);
    wr_reg(4'h7, 16'h4000);
    smp(64'h0800_1000_7FFF_7FFF, 32'h0);
    paths(16'h0800, 16'h07E0, 16'h0F80);
    for (int s = 0; s < 4; s++)
    begin
      do_reset;
      wr_reg(4'h5, 16'(s * 2 + 1));
      smp(64'h1000_1000_1000_1000, 32'h0);
      paths((s < 2) ? 16'h0200 : 16'h0000, (s == 2) ? 16'h03F0 : 16'h0000,
        (s == 3) ? 16'h0F80 : 16'h0000);
    end
    final_report;
  end

  initial
  begin
    #100000;
    fail_count++;
    final_report;
  end
endmodule // scm_mixer_clipper_tb
